/* core/bit_flag_unit.sv */
// Purpose: Bit, shift, rotate and status-flag execution unit behind an APB slave.
// Assumes: One clock; APB master follows the usual setup and access phases.
// Notes:   Every access has one wait state so that read data come from flip-flops.
//
// Operation
// (RULE1) Rotate left through carry, flags ZCNV.
// (RULE2) Rotate right through carry, flags ZCNV.
// (RULE3) Copy selected source bit into T.
// (RULE4) Copy T into selected destination bit.
// (RULE5) Set overflow flag only.
// (RULE6) Clear overflow flag only.
// (RULE7) Set or clear signed-test flag only.
// (RULE8) Set half-carry flag only.
// (RULE9) Clear half-carry flag only.
// (RULE10) Sleep gives one-cycle sleep request.
// (RULE11) Watchdog restart gives one-cycle strobe.
// (RULE12) Break only signals debug, flags untouched.
// (RULE13) Arithmetic shift right keeps bit 7, flags.
// (RULE14) Nibble swap, flags unchanged.
//
// Implementation choices: the register addresses and the APB slave port.
`include "bfiu_map.svh"

module bit_flag_unit (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             SLEEP_REQ_O,
  output logic             WDOG_RESTART_O,
  output logic             DEBUG_BREAK_O,
  output logic      [7:0]  WORK_O,
  output logic      [7:0]  STATUS_O
);

  exec_if ex ();

  logic          acc;
  logic          wr_done;
  logic          addr_hit;
  logic          ack_d,    ack_q;
  logic [31:0]   rdata_d,  rdata_q;
  logic [7:0]    work_d,   work_q;
  logic [7:0]    status_d, status_q;
  logic [7:0]    count_d,  count_q;
  bfiu_pkg::op_t last_d,   last_q;

  // Address decode is shared by the handshake, the operation issue and the write paths.
  function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : at_ofs

  // APB handshake.

  assign acc      = PSEL_I && PENABLE_I;
  assign PREADY_O = acc && ack_q;
  assign wr_done  = PREADY_O && PWRITE_I;
  assign addr_hit = at_ofs(PADDR_I, `BFIU_OFS_WORK) || at_ofs(PADDR_I, `BFIU_OFS_STATUS) ||
                    at_ofs(PADDR_I, `BFIU_OFS_OP)   || at_ofs(PADDR_I, `BFIU_OFS_STATE);
  assign PSLVERR_O = PREADY_O && !addr_hit;

  always_comb begin
    ack_d   = acc && !ack_q;
    rdata_d = rdata_q;
    if (acc && !ack_q && !PWRITE_I) begin
      unique case (PADDR_I)
        `BFIU_OFS_WORK:   rdata_d = {24'h000000, work_q};
        `BFIU_OFS_STATUS: rdata_d = {24'h000000, status_q};
        `BFIU_OFS_STATE:  rdata_d = {16'h0000, count_q, 4'h0, last_q};
        default:          rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA_O = rdata_q;

  // Operation issue. A write to the operation register executes in the same edge.

  assign ex.op      = bfiu_pkg::op_t'(PWDATA_I[`BFIU_OP_MSB:`BFIU_OP_LSB]);
  assign ex.bit_sel = PWDATA_I[`BFIU_SEL_MSB:`BFIU_SEL_LSB];
  assign ex.work    = work_q;
  assign ex.status  = status_q;
  assign ex.go      = wr_done && at_ofs(PADDR_I, `BFIU_OFS_OP);

  bit_alu i_bit_alu (
    .x (ex.alu)
  );

  ctrl_strobes i_ctrl_strobes (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .x       (ex.strb)
  );

  // Working and status registers. Software may load either directly; an issued
  // operation takes the unit's result for both, which keeps one-cycle execution.

  always_comb begin
    work_d   = work_q;
    status_d = status_q;
    count_d  = count_q;
    last_d   = last_q;
    if (ex.go) begin
      work_d   = ex.res_work;     // [RULE1] [RULE2] [RULE4] [RULE13] [RULE14]
      status_d = ex.res_status;   // [RULE3] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
      count_d  = count_q + 8'h01;
      last_d   = ex.op;
    end else if (wr_done && at_ofs(PADDR_I, `BFIU_OFS_WORK)) begin
      work_d   = PWDATA_I[7:0];
    end else if (wr_done && at_ofs(PADDR_I, `BFIU_OFS_STATUS)) begin
      status_d = PWDATA_I[7:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      work_q   <= `BFIU_RST_WORK;
      status_q <= `BFIU_RST_STATUS;
      count_q  <= 8'h00;
      last_q   <= bfiu_pkg::OP_NOP;
    end else begin
      work_q   <= work_d;
      status_q <= status_d;
      count_q  <= count_d;
      last_q   <= last_d;
    end
  end

  assign WORK_O         = work_q;
  assign STATUS_O       = status_q;
  assign SLEEP_REQ_O    = ex.sleep;   // [RULE10]
  assign WDOG_RESTART_O = ex.wdog;    // [RULE11]
  assign DEBUG_BREAK_O  = ex.brk;     // [RULE12]

  // Checks. Helper signals capture operands so that each check ties the
  // result to the state before the issuing edge.

  logic       sel_bit;
  logic [7:0] sel_mask;

  assign sel_bit  = work_q[ex.bit_sel];
  assign sel_mask = 8'h01 << ex.bit_sel;

  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (!RST_N_I);

  sequence s_issue(bfiu_pkg::op_t o);
    ex.go && (ex.op == o);
  endsequence

  sequence s_flags_follow;
    (status_q[`BFIU_FLAG_Z] == (work_q == 8'h00)) &&
    (status_q[`BFIU_FLAG_N] == work_q[7]) &&
    (status_q[`BFIU_FLAG_V] == (work_q[7] ^ status_q[`BFIU_FLAG_C]));
  endsequence

  sequence s_one_pulse(logic s);
    s ##1 !s;
  endsequence

  chk_rotl_result: assert property ( // [RULE1]
    s_issue(bfiu_pkg::OP_ROTL) |=>
      (work_q == {$past(work_q[6:0]), $past(status_q[`BFIU_FLAG_C])}) &&
      (status_q[`BFIU_FLAG_C] == $past(work_q[7])) and s_flags_follow)
    else $error("Rotate left gave a wrong result or flag.");

  chk_rotr_result: assert property ( // [RULE2]
    s_issue(bfiu_pkg::OP_ROTR) |=>
      (work_q == {$past(status_q[`BFIU_FLAG_C]), $past(work_q[7:1])}) &&
      (status_q[`BFIU_FLAG_C] == $past(work_q[0])) and s_flags_follow)
    else $error("Rotate right gave a wrong result or flag.");

  chk_tstore_flag: assert property ( // [RULE3]
    s_issue(bfiu_pkg::OP_TSTORE) |=>
      (status_q[`BFIU_FLAG_T] == $past(sel_bit)) &&
      ((status_q & 8'hbf) == ($past(status_q) & 8'hbf)) &&
      (work_q == $past(work_q)))
    else $error("Bit store did not copy the bit into T alone.");

  chk_tload_bit: assert property ( // [RULE4]
    s_issue(bfiu_pkg::OP_TLOAD) |=>
      (((work_q ^ $past(work_q)) & ~$past(sel_mask)) == 8'h00) &&
      (((work_q & $past(sel_mask)) != 8'h00) == $past(status_q[`BFIU_FLAG_T])) &&
      (status_q == $past(status_q)))
    else $error("Bit load changed the wrong bit or a flag.");

  chk_vflag_set: assert property ( // [RULE5]
    s_issue(bfiu_pkg::OP_VSET) |=>
      status_q == ($past(status_q) | 8'h08))
    else $error("Set overflow did not set only V.");

  chk_vflag_clr: assert property ( // [RULE6]
    s_issue(bfiu_pkg::OP_VCLR) |=>
      status_q == ($past(status_q) & 8'hf7))
    else $error("Clear overflow did not clear only V.");

  chk_sflag_set: assert property ( // [RULE7]
    s_issue(bfiu_pkg::OP_SSET) |=>
      status_q == ($past(status_q) | 8'h10))
    else $error("Set signed did not set only S.");

  chk_sflag_clr: assert property ( // [RULE7]
    s_issue(bfiu_pkg::OP_SCLR) |=>
      status_q == ($past(status_q) & 8'hef))
    else $error("Clear signed did not clear only S.");

  chk_hflag_set: assert property ( // [RULE8]
    s_issue(bfiu_pkg::OP_HSET) |=>
      status_q == ($past(status_q) | 8'h20))
    else $error("Set half carry did not set only H.");

  chk_hflag_clr: assert property ( // [RULE9]
    s_issue(bfiu_pkg::OP_HCLR) |=>
      status_q == ($past(status_q) & 8'hdf))
    else $error("Clear half carry did not clear only H.");

  chk_sleep_pulse: assert property ( // [RULE10]
    s_issue(bfiu_pkg::OP_SLEEP) |=>
      s_one_pulse(SLEEP_REQ_O) and
      ((work_q == $past(work_q)) && (status_q == $past(status_q))))
    else $error("Sleep request was not a lone one-cycle pulse.");

  chk_sleep_cause: assert property ( // [RULE10]
    SLEEP_REQ_O |-> $past(ex.go) && ($past(ex.op) == bfiu_pkg::OP_SLEEP))
    else $error("Sleep request without a sleep operation.");

  chk_wdog_pulse: assert property ( // [RULE11]
    s_issue(bfiu_pkg::OP_WDOG) |=>
      s_one_pulse(WDOG_RESTART_O) and
      ((work_q == $past(work_q)) && (status_q == $past(status_q))))
    else $error("Watchdog restart was not a lone one-cycle pulse.");

  chk_wdog_cause: assert property ( // [RULE11]
    WDOG_RESTART_O |-> $past(ex.go) && ($past(ex.op) == bfiu_pkg::OP_WDOG))
    else $error("Watchdog restart without its operation.");

  chk_break_flags: assert property ( // [RULE12]
    s_issue(bfiu_pkg::OP_BREAK) |=>
      DEBUG_BREAK_O && (status_q == $past(status_q)) && (work_q == $past(work_q)))
    else $error("Break changed a flag or gave no debug strobe.");

  chk_shra_result: assert property ( // [RULE13]
    s_issue(bfiu_pkg::OP_SHRA) |=>
      (work_q == {$past(work_q[7]), $past(work_q[7:1])}) &&
      (status_q[`BFIU_FLAG_C] == $past(work_q[0])) and s_flags_follow)
    else $error("Arithmetic shift right gave a wrong result or flag.");

  chk_swap_nibbles: assert property ( // [RULE14]
    s_issue(bfiu_pkg::OP_SWAP) |=>
      (work_q == {$past(work_q[3:0]), $past(work_q[7:4])}) &&
      (status_q == $past(status_q)))
    else $error("Nibble swap gave a wrong result or touched a flag.");

  chk_apb_wait: assert property (
    (acc && !ack_q) |-> !PREADY_O ##1 (!acc || PREADY_O))
    else $error("APB access did not take exactly one wait state.");

  chk_wait_clear: assert property (
    !acc |=> !ack_q)
    else $error("Wait flop stayed set outside an access.");

  chk_ready_access: assert property (
    PREADY_O |-> acc && $past(acc) && !$past(PREADY_O))
    else $error("Ready was given outside the second access cycle.");

  // Read data are captured one cycle early; these tie them to the live registers.
  sequence s_read_at(logic [7:0] a);
    PREADY_O && !PWRITE_I && at_ofs(PADDR_I, a);
  endsequence

  sequence s_write_at(logic [7:0] a);
    wr_done && at_ofs(PADDR_I, a);
  endsequence

  chk_read_work: assert property (
    s_read_at(`BFIU_OFS_WORK) |-> PRDATA_O == {24'h000000, work_q})
    else $error("Working register read returned stale data.");

  chk_read_status: assert property (
    s_read_at(`BFIU_OFS_STATUS) |-> PRDATA_O == {24'h000000, status_q})
    else $error("Status register read returned stale data.");

  chk_read_state: assert property (
    s_read_at(`BFIU_OFS_STATE) |-> PRDATA_O == {16'h0000, count_q, 4'h0, last_q})
    else $error("State register read returned stale data.");

  chk_read_zero: assert property (
    (s_read_at(`BFIU_OFS_OP) or (PREADY_O && !PWRITE_I && !addr_hit)) |->
      PRDATA_O == 32'h00000000)
    else $error("Operation or unmapped read did not return zero.");

  chk_work_write: assert property (
    s_write_at(`BFIU_OFS_WORK) |=> work_q == $past(PWDATA_I[7:0]))
    else $error("Working register write did not land.");

  chk_status_write: assert property (
    s_write_at(`BFIU_OFS_STATUS) |=> status_q == $past(PWDATA_I[7:0]))
    else $error("Status register write did not land.");

  chk_unmapped_write: assert property (
    (wr_done && !addr_hit) |=>
      (work_q == $past(work_q)) && (status_q == $past(status_q)))
    else $error("Unmapped write changed a register.");

  chk_reg_hold: assert property (
    (!ex.go && !wr_done) |=>
      (work_q == $past(work_q)) && (status_q == $past(status_q)))
    else $error("A register changed with no write and no operation.");

  chk_count_step: assert property (
    ex.go |=> count_q == $past(count_q) + 8'h01)
    else $error("Issue count did not step on an operation.");

  chk_count_hold: assert property (
    !ex.go |=> count_q == $past(count_q))
    else $error("Issue count moved without an operation.");

  chk_last_op: assert property (
    ex.go |=> last_q == $past(ex.op))
    else $error("Last operation code was not recorded.");

  chk_strobe_alone: assert property ( // [RULE10] [RULE11]
    $onehot0({SLEEP_REQ_O, WDOG_RESTART_O, DEBUG_BREAK_O}))
    else $error("More than one control strobe was high.");

  chk_break_cause: assert property ( // [RULE12]
    DEBUG_BREAK_O |-> $past(ex.go) && ($past(ex.op) == bfiu_pkg::OP_BREAK))
    else $error("Debug break without a break operation.");

endmodule : bit_flag_unit

/* core/bfiu_map.svh */
// Purpose: Offsets, field positions and reset values of the bit and flag unit.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef BFIU_MAP_SVH
`define BFIU_MAP_SVH

`define BFIU_OFS_WORK   8'h00
`define BFIU_OFS_STATUS 8'h04
`define BFIU_OFS_OP     8'h08
`define BFIU_OFS_STATE  8'h0c

`define BFIU_RST_WORK   8'h00
`define BFIU_RST_STATUS 8'h00

`define BFIU_FLAG_C 0
`define BFIU_FLAG_Z 1
`define BFIU_FLAG_N 2
`define BFIU_FLAG_V 3
`define BFIU_FLAG_S 4
`define BFIU_FLAG_H 5
`define BFIU_FLAG_T 6

`define BFIU_OP_MSB  3
`define BFIU_OP_LSB  0
`define BFIU_SEL_MSB 6
`define BFIU_SEL_LSB 4

`endif

/* core/bfiu_pkg.sv */
// Purpose: Types shared by the bit and flag unit.
// Assumes: Nothing.
// Notes:   Operation codes are written into the operation register.
package bfiu_pkg;

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_ROTL   = 4'h1,
    OP_ROTR   = 4'h2,
    OP_SHRA   = 4'h3,
    OP_SWAP   = 4'h4,
    OP_TSTORE = 4'h5,
    OP_TLOAD  = 4'h6,
    OP_VSET   = 4'h7,
    OP_VCLR   = 4'h8,
    OP_SSET   = 4'h9,
    OP_SCLR   = 4'ha,
    OP_HSET   = 4'hb,
    OP_HCLR   = 4'hc,
    OP_SLEEP  = 4'hd,
    OP_WDOG   = 4'he,
    OP_BREAK  = 4'hf
  } op_t;

endpackage : bfiu_pkg

/* core/exec_if.sv */
// Purpose: Carries one operation between the core and its helpers.
// Assumes: All signals belong to the core clock.
// Notes:   Strobe outputs are registered in the strobe module.
interface exec_if;
  bfiu_pkg::op_t op;
  logic [2:0]    bit_sel;
  logic [7:0]    work;
  logic [7:0]    status;
  logic          go;
  logic [7:0]    res_work;
  logic [7:0]    res_status;
  logic          sleep;
  logic          wdog;
  logic          brk;

  modport alu  (input op, bit_sel, work, status, output res_work, res_status);
  modport strb (input op, go, output sleep, wdog, brk);
  modport core (output op, bit_sel, work, status, go,
                input res_work, res_status, sleep, wdog, brk);
endinterface : exec_if

/* core/bit_alu.sv */
// Purpose: Combinational result and flags of one bit, shift or flag operation.
// Assumes: Operands are the current working and status registers.
// Notes:   Control operations pass both registers through unchanged.
`include "bfiu_map.svh"

module bit_alu (
  exec_if.alu x
);

  // Shift and rotate share one flag update; the signed-test flag is left alone.
  function automatic logic [7:0] shift_flags(input logic [7:0] r,
                                             input logic       c,
                                             input logic [7:0] s);
    logic [7:0] f;
    f = s;
    f[`BFIU_FLAG_C] = c;
    f[`BFIU_FLAG_Z] = (r == 8'h00);
    f[`BFIU_FLAG_N] = r[7];
    f[`BFIU_FLAG_V] = r[7] ^ c;
    return f;
  endfunction : shift_flags

  logic [7:0] r;

  always_comb begin
    r = x.work;
    x.res_status = x.status;
    unique case (x.op)
      bfiu_pkg::OP_ROTL: begin
        r = {x.work[6:0], x.status[`BFIU_FLAG_C]};                  // [RULE1]
        x.res_status = shift_flags(r, x.work[7], x.status);         // [RULE1]
      end
      bfiu_pkg::OP_ROTR: begin
        r = {x.status[`BFIU_FLAG_C], x.work[7:1]};                  // [RULE2]
        x.res_status = shift_flags(r, x.work[0], x.status);         // [RULE2]
      end
      bfiu_pkg::OP_SHRA: begin
        r = {x.work[7], x.work[7:1]};                               // [RULE13]
        x.res_status = shift_flags(r, x.work[0], x.status);         // [RULE13]
      end
      bfiu_pkg::OP_SWAP: r = {x.work[3:0], x.work[7:4]};            // [RULE14]
      bfiu_pkg::OP_TSTORE: x.res_status[`BFIU_FLAG_T] = x.work[x.bit_sel]; // [RULE3]
      bfiu_pkg::OP_TLOAD:  r[x.bit_sel] = x.status[`BFIU_FLAG_T];   // [RULE4]
      bfiu_pkg::OP_VSET:   x.res_status[`BFIU_FLAG_V] = 1'b1;       // [RULE5]
      bfiu_pkg::OP_VCLR:   x.res_status[`BFIU_FLAG_V] = 1'b0;       // [RULE6]
      bfiu_pkg::OP_SSET:   x.res_status[`BFIU_FLAG_S] = 1'b1;       // [RULE7]
      bfiu_pkg::OP_SCLR:   x.res_status[`BFIU_FLAG_S] = 1'b0;       // [RULE7]
      bfiu_pkg::OP_HSET:   x.res_status[`BFIU_FLAG_H] = 1'b1;       // [RULE8]
      bfiu_pkg::OP_HCLR:   x.res_status[`BFIU_FLAG_H] = 1'b0;       // [RULE9]
      bfiu_pkg::OP_NOP, bfiu_pkg::OP_SLEEP,
      bfiu_pkg::OP_WDOG, bfiu_pkg::OP_BREAK: r = x.work;            // [RULE12]
    endcase
    x.res_work = r;
  end

endmodule : bit_alu

/* core/ctrl_strobes.sv */
// Purpose: One-cycle strobes to sleep control, watchdog and debug logic.
// Assumes: go is high for exactly one cycle per issued operation.
// Notes:   Strobes appear in the cycle after the issuing edge.
module ctrl_strobes (
  input wire logic clk_i,
  input wire logic rst_n_i,
  exec_if.strb     x
);

  logic sleep_d, wdog_d, brk_d;
  logic sleep_q, wdog_q, brk_q;

  always_comb begin
    sleep_d = x.go && (x.op == bfiu_pkg::OP_SLEEP);   // [RULE10]
    wdog_d  = x.go && (x.op == bfiu_pkg::OP_WDOG);    // [RULE11]
    brk_d   = x.go && (x.op == bfiu_pkg::OP_BREAK);   // [RULE12]
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sleep_q <= 1'b0;
      wdog_q  <= 1'b0;
      brk_q   <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      wdog_q  <= wdog_d;
      brk_q   <= brk_d;
    end
  end

  assign x.sleep = sleep_q;
  assign x.wdog  = wdog_q;
  assign x.brk   = brk_q;

endmodule : ctrl_strobes

/* tb/tb_bit_flag_unit.sv */
// Purpose: Self-checking bench for the bit, shift and flag unit over APB.
// Assumes: One wait state per access; strobes follow the issuing edge by one cycle.
// Notes:   Expected results come from a small reference model in this file.
`include "bfiu_map.svh"

module tb_bit_flag_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_req;
  logic        wdog_restart;
  logic        debug_break;
  logic [7:0]  work;
  logic [7:0]  status;
  logic [7:0]  exp_w;
  logic [7:0]  exp_s;
  logic [3:0]  last_op;
  int          miscompares;
  int          check_count;
  int          issued;
  logic [7:0]  wv [4] = '{8'h80, 8'h00, 8'ha5, 8'h01};
  logic [7:0]  sv [4] = '{8'h00, 8'hfe, 8'hff, 8'h41};

  bit_flag_unit i_bit_flag_unit (
    .CLK_I          (clk),
    .RST_N_I        (rst_n),
    .PSEL_I         (psel),
    .PENABLE_I      (penable),
    .PWRITE_I       (pwrite),
    .PADDR_I        (paddr),
    .PWDATA_I       (pwdata),
    .PRDATA_O       (prdata),
    .PREADY_O       (pready),
    .PSLVERR_O      (pslverr),
    .SLEEP_REQ_O    (sleep_req),
    .WDOG_RESTART_O (wdog_restart),
    .DEBUG_BREAK_O  (debug_break),
    .WORK_O         (work),
    .STATUS_O       (status)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // The request is held until pready is seen high at a rising edge.
  task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          input logic [31:0] exp_rd, input logic exp_err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("ERROR %0t no ready", $time);
    end
    if (!w) begin
      chk_val(prdata, exp_rd);
    end
    chk_bit(pslverr, exp_err);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic set_regs(input logic [7:0] w, input logic [7:0] s);
    apb_xfer(`BFIU_OFS_WORK, 1'b1, {24'hffffff, w}, 32'h0, 1'b0);
    apb_xfer(`BFIU_OFS_STATUS, 1'b1, {24'h0, s}, 32'h0, 1'b0);
    exp_w = w;
    exp_s = s;
  endtask : set_regs

  function automatic logic [15:0] model(input logic [3:0] op, input logic [2:0] sel,
                                        input logic [7:0] w, input logic [7:0] s);
    logic [7:0] nw;
    logic [7:0] ns;
    logic       c;
    nw = w;
    ns = s;
    c  = s[`BFIU_FLAG_C];
    case (op)
      4'h1: begin nw = {w[6:0], c}; c = w[7]; end
      4'h2: begin nw = {c, w[7:1]}; c = w[0]; end
      4'h3: begin nw = {w[7], w[7:1]}; c = w[0]; end
      4'h4: nw = {w[3:0], w[7:4]};
      4'h5: ns[`BFIU_FLAG_T] = w[sel];
      4'h6: nw[sel] = s[`BFIU_FLAG_T];
      4'h7: ns[`BFIU_FLAG_V] = 1'b1;
      4'h8: ns[`BFIU_FLAG_V] = 1'b0;
      4'h9: ns[`BFIU_FLAG_S] = 1'b1;
      4'ha: ns[`BFIU_FLAG_S] = 1'b0;
      4'hb: ns[`BFIU_FLAG_H] = 1'b1;
      4'hc: ns[`BFIU_FLAG_H] = 1'b0;
      default: ;
    endcase
    if (op inside {4'h1, 4'h2, 4'h3}) begin
      ns[`BFIU_FLAG_C] = c;
      ns[`BFIU_FLAG_Z] = (nw == 8'h00);
      ns[`BFIU_FLAG_N] = nw[7];
      ns[`BFIU_FLAG_V] = nw[7] ^ c;
    end
    return {nw, ns};
  endfunction : model

  // Strobes are looked at in the one cycle after the issuing edge, then must be gone.
  task automatic run_op(input logic [3:0] op, input logic [2:0] sel);
    {exp_w, exp_s} = model(op, sel, exp_w, exp_s);
    apb_xfer(`BFIU_OFS_OP, 1'b1, {25'h0, sel, op}, 32'h0, 1'b0);
    issued++;
    last_op = op;
    @(negedge clk);
    chk_val({24'h0, work}, {24'h0, exp_w});
    chk_val({24'h0, status}, {24'h0, exp_s});
    chk_bit(sleep_req, op == 4'hd);
    chk_bit(wdog_restart, op == 4'he);
    chk_bit(debug_break, op == 4'hf);
    @(negedge clk);
    chk_bit(sleep_req | wdog_restart | debug_break, 1'b0);
  endtask : run_op

  initial begin
    #200000;
    miscompares++;
    $display("ERROR %0t run did not finish", $time);
    complete_run();
  end

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    issued  = 0;
    last_op = 4'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb_xfer(`BFIU_OFS_WORK, 1'b0, 32'h0, {24'h0, `BFIU_RST_WORK}, 1'b0);
    apb_xfer(`BFIU_OFS_STATUS, 1'b0, 32'h0, {24'h0, `BFIU_RST_STATUS}, 1'b0);
    apb_xfer(`BFIU_OFS_STATE, 1'b0, 32'h0, 32'h0, 1'b0);
    set_regs(8'h5a, 8'h3c);
    apb_xfer(`BFIU_OFS_WORK, 1'b0, 32'h0, 32'h5a, 1'b0);
    apb_xfer(`BFIU_OFS_OP, 1'b0, 32'h0, 32'h0, 1'b0);
    apb_xfer(8'h10, 1'b1, 32'h77, 32'h0, 1'b1);
    apb_xfer(8'h10, 1'b0, 32'h0, 32'h0, 1'b1);
    apb_xfer(`BFIU_OFS_STATUS, 1'b0, 32'h0, 32'h3c, 1'b0);
    // Every opcode on each operand pair, with the bit select walking.
    for (int k = 0; k < 4; k++) begin
      for (int op = 0; op < 16; op++) begin
        set_regs(wv[k], sv[k]);
        run_op(op[3:0], 3'(op + 3 * k));
      end
    end
    // Chained operations must each see the previous result.
    set_regs(8'hb3, 8'h00);
    repeat (9) run_op(4'h1, 3'h0);
    repeat (9) run_op(4'h2, 3'h0);
    repeat (8) run_op(4'h3, 3'h0);
    run_op(4'h5, 3'h7);
    run_op(4'h6, 3'h2);
    apb_xfer(`BFIU_OFS_STATE, 1'b0, 32'h0, {16'h0, 8'(issued), 4'h0, last_op}, 1'b0);
    apb_xfer(`BFIU_OFS_STATUS, 1'b0, 32'h0, {24'h0, exp_s}, 1'b0);
    // A reset in mid-run must clear the registers and the issue count.
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb_xfer(`BFIU_OFS_STATE, 1'b0, 32'h0, 32'h0, 1'b0);
    apb_xfer(`BFIU_OFS_WORK, 1'b0, 32'h0, {24'h0, `BFIU_RST_WORK}, 1'b0);
    apb_xfer(`BFIU_OFS_STATUS, 1'b0, 32'h0, {24'h0, `BFIU_RST_STATUS}, 1'b0);
    exp_w = `BFIU_RST_WORK;
    exp_s = `BFIU_RST_STATUS;
    run_op(4'h1, 3'h0);
    apb_xfer(`BFIU_OFS_STATE, 1'b0, 32'h0, 32'h00000101, 1'b0);
    complete_run();
  end
endmodule : tb_bit_flag_unit
